// ### rtl/slpc_consts.vh
// constants for the synthesizer latch decode and power control block
`ifndef SLPC_CONSTS_VH
`define SLPC_CONSTS_VH

// ****************************************************
// serial word and latch selection
// ****************************************************
`define SLPC_WORD_W        24
`define SLPC_SEL_CONTROL   2'h0
`define SLPC_SEL_REFERENCE 2'h1
`define SLPC_SEL_FEEDBACK  2'h2
`define SLPC_SEL_TEST      2'h3

// ****************************************************
// control word fields
// ****************************************************
`define SLPC_C_CORE_LO   2
`define SLPC_C_CNT_RST   4
`define SLPC_C_MON_LO    5
`define SLPC_C_POLARITY  8
`define SLPC_C_TRISTATE  9
`define SLPC_C_GAIN      10
`define SLPC_C_MUTE      11
`define SLPC_C_OUTLVL_LO 12
`define SLPC_C_CUR1_LO   14
`define SLPC_C_CUR2_LO   17
`define SLPC_C_PD_REQ    20
`define SLPC_C_PD_SYNC   21

// ****************************************************
// reference and feedback word fields
// ****************************************************
`define SLPC_R_DIV_LO    2
`define SLPC_R_ABL_LO    16
`define SLPC_R_PRECISION 18
`define SLPC_R_TEST      19
`define SLPC_R_BAND_LO   20
`define SLPC_N_DIV_LO    8
`define SLPC_N_GAIN      21
`define SLPC_N_MIN       13'h0003
`define SLPC_R_MIN       14'h0001

// ****************************************************
// reset values and timing
// ****************************************************
`define SLPC_WORD_RST     24'h00_0000
`define SLPC_CLK_PS       4000
`define SLPC_PHASE_ERR_PS 15000
`define SLPC_LOCK_LONG    3'h5
`define SLPC_LOCK_SHORT   3'h3
`define SLPC_PD_SYNC_EDGES 2'h2

`endif

// ### rtl/slpc_synth_ctrl.v
// latch decode, power-down and divider control of the synthesizer
`timescale 1ns/1ps
`default_nettype none
`include "slpc_consts.vh"

module slpc_synth_ctrl #(
	parameter N_W = 13,
	parameter R_W = 14
) (
	// clock (reference input) and reset
	input  wire                  clk_i,
	input  wire                  arst_n_i,
	// three-wire serial link and chip-on pin
	input  wire                  sclk_i,
	input  wire                  sdata_i,
	input  wire                  load_strobe_i,
	input  wire                  chip_on_i,
	// divided oscillator feedback
	input  wire                  feedback_i,
	// power and output state
	output reg                   powered_down_o,
	output reg                   counters_load_o,
	output reg                   ref_buffer_en_o,
	output reg                   rf_output_en_o,
	output reg                   lock_detect_o,
	// charge pump and detector
	output reg                   pump_tristate_o,
	output reg                   pump_gain_select_o,
	output reg  [2:0]            pump_current_o,
	output reg                   phase_polarity_o,
	output reg  [1:0]            antibacklash_o,
	// oscillator and monitor settings
	output reg  [1:0]            vco_output_level_o,
	output reg  [1:0]            vco_core_level_o,
	output reg  [2:0]            monitor_select_o,
	output reg                   monitor_output_pin_o,
	// divider outputs
	output reg                   ref_pulse_o,
	output reg                   fb_pulse_o,
	output reg                   band_select_tick_o
);

	// phase window rounds down to whole reference clocks
	localparam integer ERR_CYC_I = `SLPC_PHASE_ERR_PS / `SLPC_CLK_PS;
	localparam [3:0]   ERR_CYC   = ERR_CYC_I[3:0];
	localparam [1:0] ST_RUN  = 2'h0;
	localparam [1:0] ST_WAIT = 2'h1;
	localparam [1:0] ST_DOWN = 2'h2;

	// ****************************************************
	// pin synchronisers
	// ****************************************************
	reg [3:0] meta_q;
	reg [3:0] sync_q;
	reg       sclk_prev_q;
	reg       load_prev_q;
	reg       fb_prev_q;
	wire      sclk_s = sync_q[0];
	wire      sdata_s = sync_q[1];
	wire      load_s = sync_q[2];
	wire      fb_s = sync_q[3];
	wire      sclk_rise = sclk_s & ~sclk_prev_q;
	wire      load_rise = load_s & ~load_prev_q;
	wire      fb_rise = fb_s & ~fb_prev_q;
	reg       ce_meta_q;
	reg       ce_q;

	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			meta_q      <= 4'h0;
			sync_q      <= 4'h0;
			sclk_prev_q <= 1'b0;
			load_prev_q <= 1'b0;
			fb_prev_q   <= 1'b0;
			ce_meta_q   <= 1'b0;
			ce_q        <= 1'b0;
		end else begin
			meta_q      <= {feedback_i, load_strobe_i, sdata_i, sclk_i};
			sync_q      <= meta_q;
			sclk_prev_q <= sclk_s;
			load_prev_q <= load_s;
			fb_prev_q   <= fb_s;
			ce_meta_q   <= chip_on_i;
			ce_q        <= ce_meta_q;
		end
	end

	// ****************************************************
	// serial shift register and latches
	// ****************************************************
	// never gated by power-down, so words can be loaded while asleep
	reg [23:0] shift_q;
	reg [23:0] ctrl_q;
	reg [23:0] ref_q;
	reg [23:0] fb_q;
	reg        gain_q;
	wire [1:0] sel = shift_q[1:0];
	wire       wr_ctrl = load_rise & (sel == `SLPC_SEL_CONTROL);
	wire       wr_ref = load_rise & (sel == `SLPC_SEL_REFERENCE);
	wire       wr_fb = load_rise & (sel == `SLPC_SEL_FEEDBACK);

	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			shift_q <= `SLPC_WORD_RST;
			ctrl_q  <= `SLPC_WORD_RST;
			ref_q   <= `SLPC_WORD_RST;
			fb_q    <= `SLPC_WORD_RST;
			gain_q  <= 1'b0;
		end else begin
			if (sclk_rise) begin
				shift_q <= {shift_q[22:0], sdata_s};
			end
			if (wr_ctrl) begin
				ctrl_q <= shift_q;
				gain_q <= shift_q[`SLPC_C_GAIN];
			end
			if (wr_ref) begin
				ref_q <= shift_q;
			end
			if (wr_fb) begin
				fb_q   <= shift_q;
				gain_q <= shift_q[`SLPC_N_GAIN];
			end
			// test latch selection stores nothing: test bit must stay zero
		end
	end

	// ****************************************************
	// field decode
	// ****************************************************
	wire           pd_req = ctrl_q[`SLPC_C_PD_REQ];
	wire           pd_sync = ctrl_q[`SLPC_C_PD_SYNC];
	wire           cnt_rst = ctrl_q[`SLPC_C_CNT_RST];
	wire           mute = ctrl_q[`SLPC_C_MUTE];
	wire [R_W-1:0] r_raw = ref_q[`SLPC_R_DIV_LO +: R_W];
	wire [N_W-1:0] n_raw = fb_q[`SLPC_N_DIV_LO +: N_W];
	wire [1:0]     band_code = ref_q[`SLPC_R_BAND_LO +: 2];
	wire           precision = ref_q[`SLPC_R_PRECISION];
	// illegal low ratios are clamped to the least legal value
	wire [R_W-1:0] r_div = (r_raw < `SLPC_R_MIN) ? `SLPC_R_MIN : r_raw;
	wire [N_W-1:0] n_div = (n_raw < `SLPC_N_MIN) ? `SLPC_N_MIN : n_raw;

	// ****************************************************
	// power-down sequencing
	// ****************************************************
	reg  [1:0] pd_st_q;
	reg  [1:0] pd_st_d;
	reg  [1:0] edge_cnt_q;
	reg  [1:0] edge_cnt_d;
	wire       ref_tick;
	wire       pd_active = (pd_st_q == ST_DOWN);
	wire       asleep = pd_active | ~ce_q;
	wire       hold_cnt = asleep | cnt_rst;

	always @* begin
		pd_st_d    = pd_st_q;
		edge_cnt_d = edge_cnt_q;
		case (pd_st_q)
			ST_RUN: begin
				// arm from the word being latched: the control latch itself
				// only takes it at this edge, so its bits are still the old ones
				if (pd_req & ~pd_sync) begin
					pd_st_d = ST_DOWN;
				end else if (wr_ctrl & shift_q[`SLPC_C_PD_REQ] & shift_q[`SLPC_C_PD_SYNC]) begin
					pd_st_d    = ST_WAIT;
					edge_cnt_d = 2'h0;
				end
			end
			ST_WAIT: begin
				if (~pd_req) begin
					pd_st_d = ST_RUN;
				end else if (~pd_sync) begin
					pd_st_d = ST_DOWN;
				end else if (ref_tick) begin
					edge_cnt_d = edge_cnt_q + 2'h1;
					if (edge_cnt_q + 2'h1 == `SLPC_PD_SYNC_EDGES) begin
						pd_st_d = ST_DOWN;
					end
				end
			end
			ST_DOWN: begin
				if (~pd_req) begin
					pd_st_d = ST_RUN;
				end
			end
			default: begin
				pd_st_d = ST_RUN;
			end
		endcase
	end

	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pd_st_q    <= ST_RUN;
			edge_cnt_q <= 2'h0;
		end else begin
			pd_st_q    <= pd_st_d;
			edge_cnt_q <= edge_cnt_d;
		end
	end

	// ****************************************************
	// reference and feedback dividers
	// ****************************************************
	reg [R_W-1:0] r_cnt_q;
	reg [N_W-1:0] n_cnt_q;
	wire          r_end = (r_cnt_q == {R_W{1'b0}});
	wire          n_end = (n_cnt_q == {N_W{1'b0}});
	wire          fb_tick = ~hold_cnt & fb_rise & n_end;
	assign ref_tick = ~hold_cnt & r_end;

	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			r_cnt_q <= {R_W{1'b0}};
			n_cnt_q <= {N_W{1'b0}};
		end else if (hold_cnt) begin
			r_cnt_q <= r_div - 1'b1;
			n_cnt_q <= n_div - 1'b1;
		end else begin
			r_cnt_q <= r_end ? (r_div - 1'b1) : (r_cnt_q - 1'b1);
			if (fb_rise) begin
				n_cnt_q <= n_end ? (n_div - 1'b1) : (n_cnt_q - 1'b1);
			end
		end
	end

	// ****************************************************
	// lock detection
	// ****************************************************
	// phase error is read as the age of the last reference pulse
	// at the feedback pulse; only lagging feedback is judged
	reg  [3:0] ref_age_q;
	reg  [2:0] good_q;
	reg        waiting_q;
	reg        lock_q;
	wire [2:0] need = precision ? `SLPC_LOCK_LONG : `SLPC_LOCK_SHORT;
	wire       close = (ref_age_q <= ERR_CYC);

	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ref_age_q <= 4'hf;
			good_q    <= 3'h0;
			waiting_q <= 1'b0;
			lock_q    <= 1'b0;
		end else if (asleep) begin
			ref_age_q <= 4'hf;
			good_q    <= 3'h0;
			waiting_q <= 1'b0;
			lock_q    <= 1'b0;
		end else begin
			if (ref_tick) begin
				ref_age_q <= 4'h0;
			end else if (ref_age_q != 4'hf) begin
				ref_age_q <= ref_age_q + 4'h1;
			end
			if (fb_tick) begin
				waiting_q <= 1'b0;
				if (close & waiting_q) begin
					if (good_q < need) begin
						good_q <= good_q + 3'h1;
					end
					if (good_q + 3'h1 >= need) begin
						lock_q <= 1'b1;
					end
				end else begin
					good_q <= 3'h0;
					lock_q <= 1'b0;
				end
			end else if (ref_tick) begin
				waiting_q <= 1'b1;
				if (waiting_q) begin
					good_q <= 3'h0;
					lock_q <= 1'b0;
				end
			end
		end
	end

	// ****************************************************
	// band select clock divider
	// ****************************************************
	reg  [2:0] band_cnt_q;
	wire [2:0] band_mask = (3'h1 << band_code) - 3'h1;

	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			band_cnt_q <= 3'h0;
		end else if (hold_cnt) begin
			band_cnt_q <= 3'h0;
		end else if (ref_tick) begin
			band_cnt_q <= (band_cnt_q + 3'h1) & band_mask;
		end
	end

	// ****************************************************
	// registered outputs
	// ****************************************************
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			powered_down_o       <= 1'b1;
			counters_load_o      <= 1'b1;
			ref_buffer_en_o      <= 1'b0;
			rf_output_en_o       <= 1'b0;
			lock_detect_o        <= 1'b0;
			pump_tristate_o      <= 1'b1;
			pump_gain_select_o   <= 1'b0;
			pump_current_o       <= 3'h0;
			phase_polarity_o     <= 1'b0;
			antibacklash_o       <= 2'h0;
			vco_output_level_o   <= 2'h0;
			vco_core_level_o     <= 2'h0;
			monitor_select_o     <= 3'h0;
			monitor_output_pin_o <= 1'b0;
			ref_pulse_o          <= 1'b0;
			fb_pulse_o           <= 1'b0;
			band_select_tick_o   <= 1'b0;
		end else begin
			powered_down_o     <= asleep;
			counters_load_o    <= hold_cnt;
			ref_buffer_en_o    <= ~asleep;
			rf_output_en_o     <= ~asleep & (~mute | lock_q);
			// lock drops on the power-down edge, not one clock after it
			lock_detect_o      <= lock_q & ~asleep;
			pump_tristate_o    <= asleep | ctrl_q[`SLPC_C_TRISTATE];
			pump_gain_select_o <= gain_q;
			pump_current_o     <= gain_q ? ctrl_q[`SLPC_C_CUR2_LO +: 3]
				: ctrl_q[`SLPC_C_CUR1_LO +: 3];
			phase_polarity_o   <= ctrl_q[`SLPC_C_POLARITY];
			antibacklash_o     <= ref_q[`SLPC_R_ABL_LO +: 2];
			vco_output_level_o <= ctrl_q[`SLPC_C_OUTLVL_LO +: 2];
			vco_core_level_o   <= ctrl_q[`SLPC_C_CORE_LO +: 2];
			monitor_select_o   <= ctrl_q[`SLPC_C_MON_LO +: 3];
			// monitor pin carries lock; other sources stay outside this block
			monitor_output_pin_o <= lock_q & ~asleep;
			ref_pulse_o        <= ref_tick;
			fb_pulse_o         <= fb_tick;
			band_select_tick_o <= ref_tick & (band_cnt_q == 3'h0);
		end
	end

endmodule // slpc_synth_ctrl
`default_nettype wire

// ### verification/slpc_synth_ctrl_checker.sv
// assertion checker of the synthesizer latch and power control
`timescale 1ns/1ps
`default_nettype none
module slpc_checker (
	// clock and reset
	input wire logic       clk_i,
	input wire logic       arst_n_i,
	// pins
	input wire logic       chip_on_i,
	input wire logic       load_strobe_i,
	// watched outputs
	input wire logic       powered_down_o,
	input wire logic       counters_load_o,
	input wire logic       ref_buffer_en_o,
	input wire logic       rf_output_en_o,
	input wire logic       lock_detect_o,
	input wire logic       pump_tristate_o,
	input wire logic       pump_gain_select_o,
	input wire logic [2:0] pump_current_o,
	input wire logic       phase_polarity_o,
	input wire logic [1:0] antibacklash_o,
	input wire logic [1:0] vco_output_level_o,
	input wire logic [1:0] vco_core_level_o,
	input wire logic [2:0] monitor_select_o,
	input wire logic       ref_pulse_o,
	input wire logic       fb_pulse_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	// ****
	// sequences
	// ****
	// 2 clk sync plus register, with margin
	sequence s_chip_off;
		!chip_on_i [*7];
	endsequence
	sequence s_fresh_load;
		$past(load_strobe_i, 4) || $past(load_strobe_i, 5);
	endsequence
	// ****
	// properties
	// ****
	property p_sleep_state;
		powered_down_o |-> counters_load_o && pump_tristate_o && !ref_buffer_en_o
			&& !rf_output_en_o && !lock_detect_o;
	endproperty
	property p_awake_buffer;
		!powered_down_o |-> ref_buffer_en_o;
	endproperty
	property p_chip_off;
		s_chip_off |-> powered_down_o;
	endproperty
	property p_rf_awake;
		rf_output_en_o |-> ref_buffer_en_o && !powered_down_o;
	endproperty
	// pulse and hold register on the same edge, so no pulse can trail the hold; the repeat is only margin
	property p_cnt_hold;
		counters_load_o [*3] |-> !ref_pulse_o && !fb_pulse_o;
	endproperty
	property p_fb_spacing;
		fb_pulse_o |=> !fb_pulse_o [*5];
	endproperty
	property p_gain_on_load;
		$changed(pump_gain_select_o) |-> s_fresh_load;
	endproperty
	property p_fields_on_load;
		$changed({pump_current_o, phase_polarity_o, antibacklash_o, vco_output_level_o,
			vco_core_level_o, monitor_select_o}) |-> s_fresh_load;
	endproperty
	a_sleep_state: assert property (p_sleep_state) else $error("asleep not parked");
	a_awake_buffer: assert property (p_awake_buffer) else $error("buffer off awake");
	a_chip_off: assert property (p_chip_off) else $error("chip-on low ignored");
	a_rf_awake: assert property (p_rf_awake) else $error("output on while asleep");
	a_cnt_hold: assert property (p_cnt_hold) else $error("divider ran while held");
	a_fb_spacing: assert property (p_fb_spacing) else $error("feedback ratio below 3");
	a_gain_on_load: assert property (p_gain_on_load) else $error("gain moved alone");
	a_fields_on_load: assert property (p_fields_on_load) else $error("field moved alone");
endmodule // slpc_checker

bind slpc_synth_ctrl slpc_checker u_slpc_checker (
	.clk_i(clk_i), .arst_n_i(arst_n_i), .chip_on_i(chip_on_i), .load_strobe_i(load_strobe_i),
	.powered_down_o(powered_down_o), .counters_load_o(counters_load_o),
	.ref_buffer_en_o(ref_buffer_en_o), .rf_output_en_o(rf_output_en_o),
	.lock_detect_o(lock_detect_o), .pump_tristate_o(pump_tristate_o),
	.pump_gain_select_o(pump_gain_select_o), .pump_current_o(pump_current_o),
	.phase_polarity_o(phase_polarity_o), .antibacklash_o(antibacklash_o),
	.vco_output_level_o(vco_output_level_o), .vco_core_level_o(vco_core_level_o),
	.monitor_select_o(monitor_select_o), .ref_pulse_o(ref_pulse_o), .fb_pulse_o(fb_pulse_o));
`default_nettype wire

// ### verification/slpc_host.sv
// host model driving the three-wire serial link
`timescale 1ns/1ps
`default_nettype none
module slpc_host (
	// clock
	input  wire logic clk_i,
	// serial link
	output var  logic sclk_o,
	output var  logic sdata_o,
	output var  logic load_strobe_o
);
	initial begin
		sclk_o = 1'b0;
		sdata_o = 1'b0;
		load_strobe_o = 1'b0;
	end
	task automatic hold(input int n);
		repeat (n) @(negedge clk_i);
	endtask
	// 4 clk phases so every edge survives the 2-ff sampling
	task automatic write_word(input logic [23:0] w);
		for (int i = 23; i >= 0; i--) begin
			sdata_o = w[i];
			hold(4);
			sclk_o = 1'b1;
			hold(4);
			sclk_o = 1'b0;
		end
		hold(4);
		load_strobe_o = 1'b1;
		hold(8);
		load_strobe_o = 1'b0;
		sdata_o = ~w[0];
	endtask
endmodule // slpc_host
`default_nettype wire

// ### verification/tb_slpc_synth_ctrl.sv
// self-checking bench of the synthesizer latch and power control
`timescale 1ns/1ps
`default_nettype none
module tb_slpc_synth_ctrl;
	logic clk_i, arst_n_i, chip_on_i, feedback_i, sclk, sdata, load;
	logic powered_down_o, counters_load_o, ref_buffer_en_o, rf_output_en_o, lock_detect_o;
	logic pump_tristate_o, pump_gain_select_o, phase_polarity_o, monitor_output_pin_o;
	logic ref_pulse_o, fb_pulse_o, band_tick;
	logic [2:0] pump_current_o, monitor_select_o;
	logic [1:0] antibacklash_o, vco_output_level_o, vco_core_level_o;
	int miscompares = 0;
	int n_tests = 0;
	int rp = 0;
	int bt = 0;
	int gap;
	// word, then {rf_en, gain, current, polarity, tristate, out, core, monitor}
	logic [37:0] rows [5] = '{{24'h0C_E1A4, 14'h274D}, {24'h20_6502, 14'h3D4D},
		{24'h0C_D648, 14'h3CB2}, {24'hFF_FFFF, 14'h3CB2}, {24'h0C_E9A4, 14'h074D}};

	slpc_host u_slpc_host (.clk_i(clk_i), .sclk_o(sclk), .sdata_o(sdata), .load_strobe_o(load));
	slpc_synth_ctrl u_slpc_synth_ctrl (
		.clk_i(clk_i), .arst_n_i(arst_n_i), .sclk_i(sclk), .sdata_i(sdata),
		.load_strobe_i(load), .chip_on_i(chip_on_i), .feedback_i(feedback_i),
		.powered_down_o(powered_down_o), .counters_load_o(counters_load_o),
		.ref_buffer_en_o(ref_buffer_en_o), .rf_output_en_o(rf_output_en_o),
		.lock_detect_o(lock_detect_o), .pump_tristate_o(pump_tristate_o),
		.pump_gain_select_o(pump_gain_select_o), .pump_current_o(pump_current_o),
		.phase_polarity_o(phase_polarity_o), .antibacklash_o(antibacklash_o),
		.vco_output_level_o(vco_output_level_o), .vco_core_level_o(vco_core_level_o),
		.monitor_select_o(monitor_select_o), .monitor_output_pin_o(monitor_output_pin_o),
		.ref_pulse_o(ref_pulse_o), .fb_pulse_o(fb_pulse_o), .band_select_tick_o(band_tick));

	// ****
	// clock, feedback and pulse counting
	// ****
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	always begin
		repeat (5) @(negedge clk_i);
		feedback_i = ~feedback_i;
	end
	always @(posedge clk_i) if (ref_pulse_o) rp++;
	always @(posedge clk_i) if (band_tick) bt++;
	// count only pulses after the strobe has passed the sync stages
	always @(posedge load) begin
		repeat (4) @(negedge clk_i);
		rp = 0;
	end
	initial begin
		#100_000;
		miscompares++;
		end_sim();
	end

	task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wait_rp(input int n);
		for (int k = 0; k < 300 && rp < n; k++) @(negedge clk_i);
	endtask
	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// ****
	// main sequence
	// ****
	initial begin
		arst_n_i = 1'b0;
		chip_on_i = 1'b1;
		feedback_i = 1'b0;
		repeat (4) @(negedge clk_i);
		check("reset", 24'({powered_down_o, counters_load_o, pump_tristate_o}), 24'h00_0007);
		arst_n_i = 1'b1;
		repeat (4) @(negedge clk_i);
		u_slpc_host.write_word(24'h06_00C9);
		repeat (100) @(negedge clk_i);
		check("antibacklash", 24'(antibacklash_o), 24'h00_0002);
		rp = 0;
		bt = 0;
		wait_rp(1);
		for (gap = 0; rp < 2 && gap < 300; gap++) @(negedge clk_i);
		check("ref period", 24'(gap), 24'h00_0032);
		check("band tick", 24'(bt), 24'h00_0002);
		// band divider code 3: one band tick in every 8 reference pulses
		u_slpc_host.write_word(24'h36_00C9);
		rp = 0;
		bt = 0;
		repeat (3) wait_rp(16);
		check("band divide", 24'({rp[7:0], bt[7:0]}), 24'h00_1002);
		for (int i = 0; i < 5; i++) begin
			// settle gap ahead of the feedback word, scaled down to fit the run
			if (rows[i][15:14] == 2'h2) repeat (100) @(negedge clk_i);
			u_slpc_host.write_word(rows[i][37:14]);
			repeat (2) @(negedge clk_i);
			check("fields", 24'({rf_output_en_o, pump_gain_select_o, pump_current_o,
				phase_polarity_o, pump_tristate_o, vco_output_level_o, vco_core_level_o,
				monitor_select_o}), 24'(rows[i][13:0]));
		end
		// feedback period spans many reference pulses: no good cycle, no lock
		check("no lock", 24'({lock_detect_o, monitor_output_pin_o}), 24'h00_0000);
		u_slpc_host.write_word(24'h1C_E1A4);
		repeat (2) @(negedge clk_i);
		check("async down", 24'({powered_down_o, counters_load_o, pump_tristate_o,
			ref_buffer_en_o}), 24'h00_000E);
		u_slpc_host.write_word(24'h0C_D648);
		repeat (2) @(negedge clk_i);
		check("wake", 24'({powered_down_o, pump_current_o}), 24'h00_0006);
		u_slpc_host.write_word(24'h3C_E1A4);
		wait_rp(1);
		repeat (3) @(negedge clk_i);
		check("sync wait", 24'(powered_down_o), 24'h00_0000);
		wait_rp(2);
		repeat (4) @(negedge clk_i);
		check("sync down", 24'(powered_down_o), 24'h00_0001);
		u_slpc_host.write_word(24'h0C_E1A4);
		chip_on_i = 1'b0;
		repeat (8) @(negedge clk_i);
		check("chip off", 24'({powered_down_o, rf_output_en_o}), 24'h00_0002);
		chip_on_i = 1'b1;
		repeat (8) @(negedge clk_i);
		check("chip on", 24'(powered_down_o), 24'h00_0000);
		u_slpc_host.write_word(24'h0C_E1B4);
		rp = 0;
		repeat (120) @(negedge clk_i);
		check("counter hold", 24'({counters_load_o, rp[7:0]}), 24'h00_0100);
		end_sim();
	end
endmodule // tb_slpc_synth_ctrl
`default_nettype wire
